// ==== hdl/spc_pkg.sv ====
// package: register map, field positions, reset values and threshold codes for the transceiver control bank
package spc_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] SPC_CTRL_ADDR = 8'h00;
  localparam logic [7:0] SPC_STAT_ADDR = 8'h04;
  localparam int SPC_AW = 8;
  localparam int SPC_DW = 32;

  // ----------------------------------------
  // control field positions
  // ----------------------------------------
  localparam int SPC_LOOP_BIT = 13;
  localparam int SPC_EQ_OFF_BIT = 12;
  localparam int SPC_THR_HI = 11;
  localparam int SPC_THR_LO = 10;
  localparam int SPC_TX_OFF_BIT = 9;
  localparam int SPC_TX_SW_BIT = 8;
  localparam logic [5:0] SPC_CTRL_RESET = 6'h00;

  // ----------------------------------------
  // status field positions
  // ----------------------------------------
  localparam int SPC_ST_TXEN_BIT = 0;
  localparam int SPC_ST_OOB_BIT = 1;
  localparam int SPC_ST_SCAN_BIT = 2;

  // ----------------------------------------
  // signal-detect threshold codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    SPC_THR_NOMINAL = 2'h0,
    SPC_THR_LOWER = 2'h1,
    SPC_THR_RAISE = 2'h2,
    SPC_THR_RAISE2 = 2'h3
  } spc_thr_t;

  // signed steps in units of the small step; code 11 is twice code 10
  localparam logic signed [2:0] SPC_STEP_NOMINAL = 3'sh0;
  localparam logic signed [2:0] SPC_STEP_LOWER = -3'sh1;
  localparam logic signed [2:0] SPC_STEP_RAISE = 3'sh1;
  localparam logic signed [2:0] SPC_STEP_RAISE2 = 3'sh2;
endpackage

// ==== hdl/spc_ctrl_if.sv ====
// interface: decoded control bits passed from the register bank to the per-port transceiver logic
`timescale 1ns/1ps
interface spc_ctrl_if;
  logic loopback;
  logic eq_off;
  logic [1:0] thr;
  logic tx_off;
  logic tx_sw;
  modport bank (output loopback, output eq_off, output thr, output tx_off, output tx_sw);
  modport port (input loopback, input eq_off, input thr, input tx_off, input tx_sw);
endinterface

// ==== hdl/spc_port.sv ====
// per-port transceiver steering: loopback, equalizer, threshold step and tx buffer enable
`timescale 1ns/1ps
module spc_port
  import spc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  spc_ctrl_if.port ctrl,
  input wire logic tx_data_i,
  input wire logic rx_pair_i,
  input wire logic oob_active_i,
  input wire logic scan_active_i,
  output logic recov_in_o,
  output logic eq_en_o,
  output logic signed [2:0] thr_step_o,
  output logic tx_pin_o,
  output logic tx_oe_o
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire logic next_recov_in;
  wire logic next_tx_oe;
  logic signed [2:0] next_step;

  assign next_recov_in = ctrl.loopback ? tx_data_i : rx_pair_i;
  // software path when bit 8 set, otherwise oob logic outside scan
  assign next_tx_oe = ctrl.tx_sw ? ~ctrl.tx_off : (oob_active_i & ~scan_active_i);

  always_comb
  begin
    case (spc_thr_t'(ctrl.thr))
      SPC_THR_NOMINAL: next_step = SPC_STEP_NOMINAL;
      SPC_THR_LOWER: next_step = SPC_STEP_LOWER;
      SPC_THR_RAISE: next_step = SPC_STEP_RAISE;
      SPC_THR_RAISE2: next_step = SPC_STEP_RAISE2;
      default: next_step = SPC_STEP_NOMINAL;
    endcase
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      recov_in_o <= 1'b0;
      eq_en_o <= 1'b1;
      thr_step_o <= SPC_STEP_NOMINAL;
      tx_pin_o <= 1'b0;
      tx_oe_o <= 1'b0;
    end
    else
    begin
      recov_in_o <= next_recov_in;
      eq_en_o <= ~ctrl.eq_off;
      thr_step_o <= next_step;
      tx_pin_o <= tx_data_i;
      tx_oe_o <= next_tx_oe;
    end
  end
endmodule

// ==== hdl/spc_bank.sv ====
// top: wishbone register bank holding the serial transceiver control bits for all ports
//
// Functional notes
// - bit 13 set loops transmit stream into clock recovery; clear uses receive pins
// - bit 12 set disables receive cable equalizer; clear keeps it enabled
// - bits 11:10 select signal-detect threshold; 00 is nominal
// - code 01 lowers threshold one small step; code 10 raises one step
// - code 11 raises threshold by the largest step, twice code 10
// - bit 8 set, bit 9 clear: transmit pins enabled, driven from core
// - bits 8 and 9 set disable transmit buffer; bit 9 ignored if bit 8 clear
// - bit 8 clear: buffer enabled only during out-of-band, no scan active
`timescale 1ns/1ps
module spc_bank
  import spc_pkg::*;
#(
  parameter int PORTS = 4
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [SPC_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [SPC_DW-1:0] wb_dat_i,
  output logic [SPC_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic [PORTS-1:0] tx_data_i,
  input wire logic [PORTS-1:0] rx_pair_i,
  input wire logic [PORTS-1:0] oob_active_i,
  input wire logic scan_active_i,
  output logic [PORTS-1:0] clock_recovery_unit_in_o,
  output logic [PORTS-1:0] eq_en_o,
  output logic [3*PORTS-1:0] thr_step_o,
  output logic [PORTS-1:0] tx_pin_o,
  output logic [PORTS-1:0] tx_oe_o
);
  // ----------------------------------------
  // control register
  // ----------------------------------------
  // bits stored in order {loop, eq_off, thr[1:0], tx_off, tx_sw}
  logic [5:0] ctrl_q;
  spc_ctrl_if cif ();

  // ----------------------------------------
  // wishbone decode
  // ----------------------------------------
  wire logic req;
  wire logic hit_ctrl;
  wire logic hit_stat;
  wire logic wr_ctrl;
  wire logic [5:0] wr_bits;
  wire logic [5:0] next_ctrl;
  wire logic [SPC_DW-1:0] ctrl_word;
  wire logic [SPC_DW-1:0] stat_word;
  wire logic [SPC_DW-1:0] next_rdata;

  // ack is one cycle after the strobe and drops the cycle after
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign hit_ctrl = (wb_adr_i == SPC_CTRL_ADDR);
  assign hit_stat = (wb_adr_i == SPC_STAT_ADDR);
  assign wr_ctrl = req & wb_we_i & hit_ctrl;
  assign wr_bits = {wb_dat_i[SPC_LOOP_BIT], wb_dat_i[SPC_EQ_OFF_BIT],
                    wb_dat_i[SPC_THR_HI:SPC_THR_LO], wb_dat_i[SPC_TX_OFF_BIT], wb_dat_i[SPC_TX_SW_BIT]};
  // byte 1 holds all six bits; other lanes are reserved
  assign next_ctrl = (wr_ctrl & wb_sel_i[1]) ? wr_bits : ctrl_q;
  assign ctrl_word = {18'h0, ctrl_q[5:4], ctrl_q[3:2], ctrl_q[1:0], 8'h00};
  // ----------------------------------------
  // port instances and status
  // ----------------------------------------
  logic [2:0] scan_sync;
  wire logic scan_lvl;
  logic scan_q;
  assign scan_lvl = (scan_sync[1] == scan_sync[2]) ? scan_sync[2] : scan_q;

  logic [PORTS-1:0] oob_s1;
  logic [PORTS-1:0] oob_s2;
  logic [PORTS-1:0] oob_s3;
  logic [PORTS-1:0] oob_q;
  wire logic [PORTS-1:0] oob_lvl;
  assign oob_lvl = (oob_s2 & oob_s3) | (oob_q & (oob_s2 | oob_s3));

  assign stat_word = {{(SPC_DW-3){1'b0}}, scan_q, |oob_q, |tx_oe_o};
  assign next_rdata = hit_ctrl ? ctrl_word : (hit_stat ? stat_word : {SPC_DW{1'b0}});

  assign cif.loopback = ctrl_q[5];
  assign cif.eq_off = ctrl_q[4];
  assign cif.thr = ctrl_q[3:2];
  assign cif.tx_off = ctrl_q[1];
  assign cif.tx_sw = ctrl_q[0];

  genvar g;
  generate
    for (g = 0; g < PORTS; g = g + 1)
    begin : g_port
      spc_port u_port (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ctrl(cif.port),
        .tx_data_i(tx_data_i[g]),
        .rx_pair_i(rx_pair_i[g]),
        .oob_active_i(oob_q[g]),
        .scan_active_i(scan_q),
        .recov_in_o(clock_recovery_unit_in_o[g]),
        .eq_en_o(eq_en_o[g]),
        .thr_step_o(thr_step_o[3*g +: 3]),
        .tx_pin_o(tx_pin_o[g]),
        .tx_oe_o(tx_oe_o[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= SPC_CTRL_RESET;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= {SPC_DW{1'b0}};
    end
    else
    begin
      ctrl_q <= next_ctrl;
      wb_ack_o <= req & (hit_ctrl | hit_stat);
      wb_err_o <= req & ~(hit_ctrl | hit_stat);
      wb_dat_o <= (req & ~wb_we_i) ? next_rdata : {SPC_DW{1'b0}};
    end
  end

  // external levels pass three flops; a change counts when the last two agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scan_sync <= 3'h0;
      scan_q <= 1'b0;
      oob_s1 <= '0;
      oob_s2 <= '0;
      oob_s3 <= '0;
      oob_q <= '0;
    end
    else
    begin
      scan_sync <= {scan_sync[1:0], scan_active_i};
      scan_q <= scan_lvl;
      oob_s1 <= oob_active_i;
      oob_s2 <= oob_s1;
      oob_s3 <= oob_s2;
      oob_q <= oob_lvl;
    end
  end
endmodule

// ==== dv/spc_bank_assertions.sv ====
// checker: bus timing and decoded outputs of the transceiver control bank
`timescale 1ns/1ps
module spc_bank_assertions
  import spc_pkg::*;
#(parameter int PORTS = 4)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [SPC_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [SPC_DW-1:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic [PORTS-1:0] tx_data_i,
  input wire logic [PORTS-1:0] rx_pair_i,
  input wire logic [PORTS-1:0] oob_active_i,
  input wire logic scan_active_i,
  input wire logic [PORTS-1:0] clock_recovery_unit_in_o,
  input wire logic [PORTS-1:0] eq_en_o,
  input wire logic [3*PORTS-1:0] thr_step_o,
  input wire logic [PORTS-1:0] tx_oe_o
);
  // shadow of bits 13:8 taken at the ack edge, so it lines up with the registered outputs
  logic [5:0] sh;
  logic req;
  logic [2:0] st;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign st = sh[3:2] == 2'h1 ? 3'h7 : {1'b0, sh[3:2] == 2'h3, sh[3:2] == 2'h2};
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sh <= 6'h00;
    else if (wb_ack_o && wb_we_i && wb_adr_i == SPC_CTRL_ADDR && wb_sel_i[1])
      sh <= wb_dat_i[13:8];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_time: assert property (req && wb_adr_i == SPC_CTRL_ADDR |=> wb_ack_o) else $error("no ack");
  chk_err_unmap: assert property (req && wb_adr_i > SPC_STAT_ADDR |=> wb_err_o && !wb_ack_o) else $error("no err");
  chk_reset_vals: assert property (disable iff (1'b0) rst_i |=> eq_en_o == '1 && thr_step_o == '0 && tx_oe_o == '0)
    else $error("reset values");
  chk_loop_src: assert property (!$past(rst_i) |-> clock_recovery_unit_in_o ==
    (sh[5] ? $past(tx_data_i) : $past(rx_pair_i))) else $error("recovery source");
  chk_eq_ctrl: assert property (eq_en_o == {PORTS{!sh[4]}}) else $error("equalizer");
  chk_thr_step: assert property (thr_step_o == {PORTS{st}}) else $error("threshold");
  chk_tx_sw: assert property (sh[0] |-> tx_oe_o == {PORTS{!sh[1]}}) else $error("sw enable");
  chk_tx_oob: assert property ((!sh[0] && !scan_active_i && $stable(oob_active_i))[*8] |->
    tx_oe_o == oob_active_i) else $error("oob enable");
  cover property (wb_err_o);
  cover property (sh[5]);
  cover property (!sh[0] && tx_oe_o != '0);
endmodule

bind spc_bank spc_bank_assertions #(.PORTS(PORTS)) chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_err_o, .tx_data_i, .rx_pair_i, .oob_active_i,
  .scan_active_i, .clock_recovery_unit_in_o, .eq_en_o, .thr_step_o, .tx_oe_o);

// ==== dv/spc_link_model.sv ====
// far side model: receive pair and out-of-band activity of the attached link
`timescale 1ns/1ps
module spc_link_model
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] oob_req_i,
  output logic [3:0] rx_pair_o,
  output logic [3:0] oob_active_o
);
  // receive value moves by 3 every cycle so a sample up to 15 cycles stale never passes
  always_ff @(posedge clk_i)
  begin
    rx_pair_o <= rst_i ? 4'h1 : rx_pair_o + 4'h3;
    oob_active_o <= oob_req_i;
  end
endmodule

// ==== dv/spc_bank_tb.sv ====
// testbench: control bank over wishbone, facing the link model
`timescale 1ns/1ps
module spc_bank_tb;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, scan_active_i = 0, wb_ack_o, wb_err_o, e;
  logic [7:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = '0, tx_data_i = '0, oob_req = '0, rx_pair_i, oob_active_i;
  logic [3:0] clock_recovery_unit_in_o, eq_en_o, tx_pin_o, tx_oe_o;
  logic [31:0] wb_dat_i = '0, wb_dat_o, q;
  logic [11:0] thr_step_o;
  int n_errors = 0, total_checks = 0, cyc = 0;
  // {bits 13:8, eq enable, step, tx enable}
  logic [10:0] rows [10] = '{11'h010, 11'h031, 11'h070, 11'h050, 11'h09e, 11'h112, 11'h194, 11'h200, 11'h410, 11'h7e4};
  spc_bank #(.PORTS(4)) dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .wb_err_o, .tx_data_i, .rx_pair_i, .oob_active_i, .scan_active_i,
    .clock_recovery_unit_in_o, .eq_en_o, .thr_step_o, .tx_pin_o, .tx_oe_o);
  spc_link_model link (.clk_i, .rst_i, .oob_req_i(oob_req), .rx_pair_o(rx_pair_i), .oob_active_o(oob_active_i));
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic ck(input logic [31:0] g, x);
    total_checks++;
    if (g !== x)
    begin
      n_errors++;
      $display("wrong value at %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    do
      @(posedge clk_i);
    while (!wb_ack_o && !wb_err_o);
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    tx_data_i <= tx_data_i + 4'h1;
    if (++cyc == 5000)
    begin
      n_errors++;
      $display("wrong value at %0t timeout", $time);
      test_done();
    end
  end
  initial
  begin
    repeat (7) @(posedge clk_i);
    #1;
    ck({eq_en_o, thr_step_o, tx_oe_o}, 20'hf0000);
    @(posedge clk_i);
    rst_i <= 0;
    wb(0, 8'h00, 0);
    ck(q, 0);
    foreach (rows[i])
    begin
      wb(1, 8'h00, {rows[i][10:5], 8'h00});
      repeat (3) @(posedge clk_i);
      #1;
      ck({eq_en_o, thr_step_o, tx_oe_o}, {{4{rows[i][4]}}, {4{rows[i][3:1]}}, {4{rows[i][0]}}});
      ck(clock_recovery_unit_in_o, rows[i][10] ? 4'(tx_data_i - 4'h1) : 4'(rx_pair_i - 4'h3));
      ck(tx_pin_o, 4'(tx_data_i - 4'h1));
    end
    wb(1, 8'h08, 0);
    ck(e, 1);
    wb(0, 8'h00, 0);
    ck(q, 32'h3f00);
    wb(1, 8'h00, 32'h0200);
    oob_req <= 4'h5;
    repeat (8) @(posedge clk_i);
    #1;
    ck(tx_oe_o, 4'h5);
    wb(0, 8'h04, 0);
    ck(q, 32'h3);
    @(posedge clk_i);
    scan_active_i <= 1;
    repeat (8) @(posedge clk_i);
    #1;
    ck(tx_oe_o, 0);
    wb(0, 8'h04, 0);
    ck(q, 32'h6);
    @(posedge clk_i);
    rst_i <= 1;
    @(posedge clk_i);
    rst_i <= 0;
    wb(0, 8'h00, 0);
    ck(q, 0);
    test_done();
  end
endmodule
